// *** bcm_pkg.sv ***
// bcm_pkg: constants shared by the bus-controller message control logic
// assumes a 32-bit classic Wishbone register bus and a 16-bit message ram
package bcm_pkg;

  // register byte offsets
  localparam logic [7:0] REG_FRAME_A_PTR = 8'h00;
  localparam logic [7:0] REG_FRAME_A_LEN = 8'h04;
  localparam logic [7:0] REG_FRAME_B_PTR = 8'h08;
  localparam logic [7:0] REG_FRAME_B_LEN = 8'h0c;
  localparam logic [7:0] REG_CONFIG1 = 8'h10;
  localparam logic [7:0] REG_CONFIG3 = 8'h14;
  localparam logic [7:0] REG_COMMAND = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_LAST_CTL = 8'h20;

  localparam int ADDR_W = 16;
  localparam int LEN_W = 10;

  // configuration 1 fields
  localparam int CFG1_OVR_EN = 0;
  localparam int CFG1_OVR_BUS = 1;
  localparam int CFG1_GRETRY_LO = 2;
  localparam logic [15:0] CFG1_MASK = 16'h000f;
  // configuration 3 field: broadcast bit used as mask when set
  localparam int CFG3_BROADCAST_RCVD_CTRL_MASK = 5;
  localparam logic [15:0] CFG3_MASK = 16'h0020;

  // command register bits
  localparam int CMD_START_A = 0;
  localparam int CMD_START_B = 1;
  localparam int CMD_STOP = 2;

  // message control word fields
  localparam int CW_DONE = 15;
  localparam int CW_RETRIED = 14;
  localparam int CW_MISMATCH = 13;
  localparam int CW_ERROR = 12;
  localparam int CW_NO_ANSWER = 11;
  localparam int CW_ACTIVE = 10;
  localparam int CW_RETRY_HI = 9;
  localparam int CW_RETRY_LO = 8;
  localparam int CW_BUS = 7;
  localparam int CW_FLAG_RESV = 6;
  localparam int CW_SERVICE = 5;
  localparam int CW_BROADCAST_RCVD_CTRL = 4;
  localparam int CW_BUSY = 3;
  localparam int CW_SUBSYS = 2;
  localparam int CW_MSG_ERROR_MASK = 1;
  localparam int CW_RTRT = 0;
  localparam logic [15:0] CW_SW_MASK = 16'h03ff;
  // result bits that come from the terminal's answer
  localparam logic [15:0] CW_RESULT_MASK = 16'h3800;

  // remote terminal status word fields
  localparam int SW_ADDR_HI = 15;
  localparam int SW_ADDR_LO = 11;
  localparam int SW_MSG_ERROR_MASK = 10;
  localparam int SW_INSTR = 9;
  localparam int SW_SERVICE = 8;
  localparam int SW_RESV_HI = 7;
  localparam int SW_RESV_LO = 5;
  localparam int SW_BROADCAST_RCVD_CTRL = 4;
  localparam int SW_BUSY = 3;
  localparam int SW_SUBSYS = 2;
  localparam int SW_TFLAG = 0;

  // retry selections
  localparam logic [1:0] RETRY_NONE = 2'h0;
  localparam logic [1:0] RETRY_ACTIVE = 2'h1;
  localparam logic [1:0] RETRY_ALT = 2'h2;
  localparam logic [1:0] RETRY_ALT_ACT = 2'h3;

  localparam logic [ADDR_W-1:0] CMD_WORD_OFS = 16'h0001;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_PTR = 9'h002,
    ST_CTL = 9'h004,
    ST_CMD = 9'h008,
    ST_MARK = 9'h010,
    ST_SEND = 9'h020,
    ST_WAIT = 9'h040,
    ST_DONE = 9'h080,
    ST_NEXT = 9'h100
  } bcm_state_type;

endpackage : bcm_pkg

// *** bcm_status_eval.sv ***
// bcm_status_eval: judges a returned terminal status word against the masks
// assumes the status word and control bits are stable while sampled
module bcm_status_eval
  import bcm_pkg::*;
(
  // returned status and expectation
  input wire logic [15:0] status_word,
  input wire logic [4:0] expect_addr,
  // software masks from the control word; mask mode from configuration 3
  input wire logic [9:0] ctl_setup,
  input wire logic broadcast_rcvd_ctrl_mask_mode,
  // verdict
  output logic mismatch
);

  logic wrong_addr;
  logic flag_hit;
  logic broadcast_rcvd_ctrl_hit;
  logic other_hit;

  assign wrong_addr = status_word[SW_ADDR_HI:SW_ADDR_LO] != expect_addr; // [R06]
  assign flag_hit = ctl_setup[CW_FLAG_RESV] &
    (status_word[SW_TFLAG] | status_word[SW_INSTR] |
     (|status_word[SW_RESV_HI:SW_RESV_LO])); // [R13]
  assign broadcast_rcvd_ctrl_hit = broadcast_rcvd_ctrl_mask_mode ?
    (ctl_setup[CW_BROADCAST_RCVD_CTRL] & status_word[SW_BROADCAST_RCVD_CTRL]) : // [R16]
    (ctl_setup[CW_BROADCAST_RCVD_CTRL] != status_word[SW_BROADCAST_RCVD_CTRL]); // [R15]
  assign other_hit = (ctl_setup[CW_SERVICE] & status_word[SW_SERVICE]) | // [R14]
    (ctl_setup[CW_BUSY] & status_word[SW_BUSY]) |
    (ctl_setup[CW_SUBSYS] & status_word[SW_SUBSYS]) |
    (ctl_setup[CW_MSG_ERROR_MASK] & status_word[SW_MSG_ERROR_MASK]); // [R17]
  assign mismatch = wrong_addr | flag_hit | broadcast_rcvd_ctrl_hit | other_hit; // [R06]

endmodule : bcm_status_eval

// *** bcm_retry_plan.sv ***
// bcm_retry_plan: decides whether a failed attempt is repeated and on which bus
// assumes attempt counts failed tries so far, starting at zero
module bcm_retry_plan
  import bcm_pkg::*;
(
  // selections
  input wire logic [1:0] local_retry_sel,
  input wire logic [1:0] global_sel,
  // progress
  input wire logic [1:0] attempt,
  input wire logic first_bus,
  // decision
  output logic again,
  output logic next_bus
);

  logic [1:0] eff_sel;

  // local none falls back to the global choice
  assign eff_sel = (local_retry_sel == RETRY_NONE) ? global_sel : local_retry_sel; // [R11]

  always_comb begin
    again = 1'b0;
    next_bus = first_bus;
    case (eff_sel) // [R10]
      RETRY_ACTIVE: begin
        again = (attempt == 2'h0);
      end
      RETRY_ALT: begin
        again = (attempt == 2'h0);
        next_bus = ~first_bus;
      end
      RETRY_ALT_ACT: begin
        again = (attempt != 2'h2);
        next_bus = (attempt == 2'h0) ? ~first_bus : first_bus;
      end
      default: begin
        again = 1'b0; // [R11]
      end
    endcase
  end

endmodule : bcm_retry_plan

// *** bcm_msg_ctrl.sv ***
// bcm_msg_ctrl: bus-controller message list walker with control word upkeep
// assumes a single-port 16-bit message ram with req/ack handshake and a
// front end that sends a command and reports the terminal's answer
//
// How it works
// R01 - software keeps each list at most 1023 entries
// R02 - writing pointer and length starts frame A/B
// R03 - software owns bits 9:0, device bits 15:10
// R04 - device sets bit 15 when message completes
// R05 - device sets bit 14 when a retry happened
// R06 - bit 13 on wrong address or enabled bit
// R07 - bit 12 when the response held an error
// R08 - bit 11 when the terminal did not answer
// R09 - bit 10 held high while message in progress
// R10 - bits 9:8 choose the local retry scheme
// R11 - local none defers to global; both none: no retry
// R12 - bit 7 picks bus; configuration 1 may override
// R13 - bit 6 enables flag, reserved, instrumentation bits
// R14 - bit 5 enables the service request bit
// R15 - compare mode: broadcast bit differing sets bit 13
// R16 - mask mode: bit 4 enables broadcast bit
// R17 - bits 3:1 enable busy, subsystem, message error
// R18 - bit 0 marks a terminal-to-terminal transfer
// R19 - result write keeps the low ten bits; the done write sets bit 7 to the bus last used
// R20 - active cleared together with done being set
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
module bcm_msg_ctrl
  import bcm_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // wishbone slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_W,
  output logic [31:0] WB_DAT_R,
  output logic WB_ACK,
  // message ram master
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [bcm_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  input wire logic [15:0] MEM_RDATA,
  input wire logic MEM_ACK,
  // front end
  output logic XMIT_START,
  output logic XMIT_BUS,
  output logic XMIT_RTRT,
  output logic [15:0] XMIT_CMD,
  input wire logic RESP_DONE,
  input wire logic [15:0] RESP_STATUS,
  input wire logic RESP_ERROR,
  input wire logic RESP_NONE,
  // state
  output logic BUSY
);

  bcm_state_type state;

  logic [ADDR_W-1:0] frame_a_ptr;
  logic [LEN_W-1:0] frame_a_len;
  logic [ADDR_W-1:0] frame_b_ptr;
  logic [LEN_W-1:0] frame_b_len;
  logic [15:0] config1;
  logic [15:0] config3;
  logic start_a;
  logic start_b;
  logic stop_req;
  logic stop_pending;
  logic frame_is_b;
  logic [ADDR_W-1:0] list_addr;
  logic [LEN_W-1:0] remaining;
  logic [LEN_W-1:0] msg_index;
  logic [ADDR_W-1:0] table_addr;
  logic [15:0] ctl_word;
  logic [15:0] cmd_word;
  logic first_bus;
  logic cur_bus;
  logic [1:0] attempt;
  logic retried;
  logic [15:0] last_ctl;
  logic mismatch;
  logic retry_again;
  logic retry_bus;
  logic failed;
  logic wb_req;
  logic [31:0] lane_mask;
  logic [31:0] read_word;
  logic [15:0] result_hi;

  assign wb_req = WB_CYC & WB_STB & ~WB_ACK;
  assign lane_mask = {{8{WB_SEL[3]}}, {8{WB_SEL[2]}}, {8{WB_SEL[1]}}, {8{WB_SEL[0]}}};
  assign failed = RESP_ERROR | RESP_NONE;

  bcm_status_eval u_status_eval (
    .status_word(RESP_STATUS),
    .expect_addr(cmd_word[SW_ADDR_HI:SW_ADDR_LO]),
    .ctl_setup(ctl_word[9:0]),
    .broadcast_rcvd_ctrl_mask_mode(config3[CFG3_BROADCAST_RCVD_CTRL_MASK]),
    .mismatch(mismatch)
  );

  bcm_retry_plan u_retry_plan (
    .local_retry_sel(ctl_word[CW_RETRY_HI:CW_RETRY_LO]),
    .global_sel(config1[CFG1_GRETRY_LO+1:CFG1_GRETRY_LO]),
    .attempt(attempt),
    .first_bus(first_bus),
    .again(retry_again),
    .next_bus(retry_bus)
  );

  // register writes; start strobes are one-cycle pulses
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      frame_a_ptr <= '0;
      frame_a_len <= '0;
      frame_b_ptr <= '0;
      frame_b_len <= '0;
      config1 <= '0;
      config3 <= '0;
      start_a <= 1'b0;
      start_b <= 1'b0;
      stop_req <= 1'b0;
    end else begin
      start_a <= 1'b0;
      start_b <= 1'b0;
      stop_req <= 1'b0;
      if (wb_req && WB_WE) begin
        if (WB_ADR == REG_FRAME_A_PTR) begin
          frame_a_ptr <= (frame_a_ptr & ~lane_mask[15:0]) | (WB_DAT_W[15:0] & lane_mask[15:0]);
        end else if (WB_ADR == REG_FRAME_A_LEN) begin
          frame_a_len <= (frame_a_len & ~lane_mask[LEN_W-1:0]) |
            (WB_DAT_W[LEN_W-1:0] & lane_mask[LEN_W-1:0]);
          start_a <= 1'b1; // [R02]
        end else if (WB_ADR == REG_FRAME_B_PTR) begin
          frame_b_ptr <= (frame_b_ptr & ~lane_mask[15:0]) | (WB_DAT_W[15:0] & lane_mask[15:0]);
        end else if (WB_ADR == REG_FRAME_B_LEN) begin
          frame_b_len <= (frame_b_len & ~lane_mask[LEN_W-1:0]) |
            (WB_DAT_W[LEN_W-1:0] & lane_mask[LEN_W-1:0]);
          start_b <= 1'b1; // [R02]
        end else if (WB_ADR == REG_CONFIG1) begin
          config1 <= ((config1 & ~lane_mask[15:0]) | (WB_DAT_W[15:0] & lane_mask[15:0]))
            & CFG1_MASK;
        end else if (WB_ADR == REG_CONFIG3) begin
          config3 <= ((config3 & ~lane_mask[15:0]) | (WB_DAT_W[15:0] & lane_mask[15:0]))
            & CFG3_MASK;
        end else if (WB_ADR == REG_COMMAND && WB_SEL[0]) begin
          start_a <= WB_DAT_W[CMD_START_A];
          start_b <= WB_DAT_W[CMD_START_B];
          stop_req <= WB_DAT_W[CMD_STOP];
        end
      end
    end
  end

  always_comb begin
    read_word = '0;
    if (WB_ADR == REG_FRAME_A_PTR) begin
      read_word[ADDR_W-1:0] = frame_a_ptr;
    end else if (WB_ADR == REG_FRAME_A_LEN) begin
      read_word[LEN_W-1:0] = frame_a_len;
    end else if (WB_ADR == REG_FRAME_B_PTR) begin
      read_word[ADDR_W-1:0] = frame_b_ptr;
    end else if (WB_ADR == REG_FRAME_B_LEN) begin
      read_word[LEN_W-1:0] = frame_b_len;
    end else if (WB_ADR == REG_CONFIG1) begin
      read_word[15:0] = config1;
    end else if (WB_ADR == REG_CONFIG3) begin
      read_word[15:0] = config3;
    end else if (WB_ADR == REG_STATUS) begin
      read_word = {6'h00, msg_index, 14'h0000, frame_is_b, BUSY};
    end else if (WB_ADR == REG_LAST_CTL) begin
      read_word[15:0] = last_ctl;
    end
  end

  // single-wait-state slave; unmapped addresses ack with zero
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK <= 1'b0;
      WB_DAT_R <= '0;
    end else begin
      WB_ACK <= wb_req;
      if (wb_req) begin
        WB_DAT_R <= WB_WE ? 32'h0000_0000 : read_word;
      end
    end
  end

  // upper six bits of a result write; low ten kept from the fetched word, except bit 7, which the done write sets to the bus last used
  always_comb begin
    result_hi = '0; // [R03]
    result_hi[CW_RETRIED] = retried; // [R05]
    result_hi[CW_ACTIVE] = (state == ST_MARK); // [R09]
    result_hi[CW_DONE] = (state == ST_DONE); // [R04]
  end

  // message sequencer and ram master
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      BUSY <= 1'b0;
      frame_is_b <= 1'b0;
      list_addr <= '0;
      remaining <= '0;
      msg_index <= '0;
      table_addr <= '0;
      ctl_word <= '0;
      cmd_word <= '0;
      first_bus <= 1'b0;
      cur_bus <= 1'b0;
      attempt <= '0;
      retried <= 1'b0;
      last_ctl <= '0;
      stop_pending <= 1'b0;
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_ADDR <= '0;
      MEM_WDATA <= '0;
      XMIT_START <= 1'b0;
      XMIT_BUS <= 1'b0;
      XMIT_RTRT <= 1'b0;
      XMIT_CMD <= '0;
    end else begin
      XMIT_START <= 1'b0;
      // a stop is a pulse; keep it until the running message ends
      if (stop_req) begin
        stop_pending <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          stop_pending <= 1'b0;
          if (start_a && frame_a_len != '0) begin
            list_addr <= frame_a_ptr; // [R02]
            remaining <= frame_a_len;
            frame_is_b <= 1'b0;
            msg_index <= '0;
            BUSY <= 1'b1;
            state <= ST_PTR;
          end else if (start_b && frame_b_len != '0) begin
            list_addr <= frame_b_ptr; // [R02]
            remaining <= frame_b_len;
            frame_is_b <= 1'b1;
            msg_index <= '0;
            BUSY <= 1'b1;
            state <= ST_PTR;
          end
        end
        ST_PTR: begin
          if (!MEM_REQ) begin
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b0;
            MEM_ADDR <= list_addr;
          end else if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            table_addr <= MEM_RDATA;
            state <= ST_CTL;
          end
        end
        ST_CTL: begin
          if (!MEM_REQ) begin
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b0;
            MEM_ADDR <= table_addr;
          end else if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            ctl_word <= MEM_RDATA;
            state <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (!MEM_REQ) begin
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b0;
            MEM_ADDR <= table_addr + CMD_WORD_OFS;
          end else if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            cmd_word <= MEM_RDATA;
            attempt <= '0;
            retried <= 1'b0;
            // configuration 1 override beats the per-message bus bit
            if (config1[CFG1_OVR_EN]) begin
              first_bus <= config1[CFG1_OVR_BUS]; // [R12]
              cur_bus <= config1[CFG1_OVR_BUS];
            end else begin
              first_bus <= ctl_word[CW_BUS]; // [R12]
              cur_bus <= ctl_word[CW_BUS];
            end
            state <= ST_MARK;
          end
        end
        ST_MARK: begin
          if (!MEM_REQ) begin
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b1;
            MEM_ADDR <= table_addr;
            MEM_WDATA <= result_hi | (ctl_word & CW_SW_MASK); // [R19]
          end else if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          XMIT_START <= 1'b1;
          XMIT_BUS <= cur_bus;
          XMIT_RTRT <= ctl_word[CW_RTRT]; // [R18]
          XMIT_CMD <= cmd_word;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (RESP_DONE) begin
            if (failed && retry_again) begin
              attempt <= attempt + 2'h1;
              retried <= 1'b1; // [R05]
              cur_bus <= retry_bus; // [R10]
              state <= ST_SEND;
            end else begin
              ctl_word[CW_MISMATCH] <= ~RESP_NONE & mismatch; // [R06]
              ctl_word[CW_ERROR] <= RESP_ERROR; // [R07]
              ctl_word[CW_NO_ANSWER] <= RESP_NONE; // [R08]
              ctl_word[CW_BUS] <= cur_bus; // [R12]
              state <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          if (!MEM_REQ) begin
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b1;
            MEM_ADDR <= table_addr;
            // done set and active cleared in one write
            MEM_WDATA <= result_hi | (ctl_word & (CW_SW_MASK | CW_RESULT_MASK)); // [R20]
          end else if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
            last_ctl <= MEM_WDATA;
            state <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          remaining <= remaining - 10'h001;
          msg_index <= msg_index + 10'h001;
          list_addr <= list_addr + 16'h0001;
          if (remaining == 10'h001 || stop_req || stop_pending) begin
            BUSY <= 1'b0;
            stop_pending <= 1'b0;
            state <= ST_IDLE;
          end else begin
            state <= ST_PTR;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : bcm_msg_ctrl

// *** bcm_msg_ctrl_properties.sv ***
// bcm_msg_ctrl_properties: port checks of the message controller
// assumes it is bound to bcm_msg_ctrl and sees only its ports
module bcm_msg_ctrl_properties (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // register bus
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_ACK,
  // ram and front end
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic XMIT_START,
  input wire logic RESP_DONE,
  input wire logic RESP_ERROR,
  input wire logic RESP_NONE,
  input wire logic BUSY
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_taken;
    WB_CYC && WB_STB && !WB_ACK;
  endsequence
  sequence s_mark;
    MEM_REQ && MEM_WE && MEM_WDATA[10];
  endsequence
  sequence s_good_end;
    RESP_DONE && !RESP_ERROR && !RESP_NONE;
  endsequence

  a_wb_ack_once: assert property (s_taken |=> WB_ACK ##1 !WB_ACK)
    else $error("register access not answered in one cycle");
  a_mark_only_active: assert property (s_mark |-> MEM_WDATA[15:11] == 5'h00)
    else $error("active write carries result bits");
  a_done_not_active: assert property (MEM_REQ && MEM_WE && MEM_WDATA[15] |-> !MEM_WDATA[10])
    else $error("done written with active still set");
  a_mark_then_send: assert property (s_mark ##0 MEM_ACK |-> ##[1:8] XMIT_START)
    else $error("no send after active write");
  a_good_end_done: assert property (s_good_end |->
    ##[1:3] (MEM_REQ && MEM_WE && MEM_WDATA[15] && MEM_WDATA[12:11] == 2'h0))
    else $error("clean answer not written as done");
  a_none_flagged: assert property (RESP_DONE && RESP_NONE |-> ##[1:3]
    (XMIT_START || (MEM_REQ && MEM_WE && MEM_WDATA[11] && !MEM_WDATA[13])))
    else $error("missing answer not flagged");
  a_error_flagged: assert property (RESP_DONE && RESP_ERROR && !RESP_NONE |->
    ##[1:3] (XMIT_START || (MEM_REQ && MEM_WE && MEM_WDATA[12])))
    else $error("answer error not flagged");
  a_req_stands: assert property (MEM_REQ && !MEM_ACK |=>
    MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WDATA))
    else $error("ram request changed before answer");
  a_send_busy: assert property (XMIT_START |-> BUSY)
    else $error("send outside a running frame");
endmodule : bcm_msg_ctrl_properties

bind bcm_msg_ctrl bcm_msg_ctrl_properties chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_ACK(WB_ACK), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
  .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .XMIT_START(XMIT_START),
  .RESP_DONE(RESP_DONE), .RESP_ERROR(RESP_ERROR), .RESP_NONE(RESP_NONE), .BUSY(BUSY));

// *** bcm_far_end.sv ***
// bcm_far_end: message ram and remote terminals facing the controller
// assumes the bench presets ram, latencies and answers hierarchically
module bcm_far_end (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // message ram
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  // front end
  input wire logic xmit_start,
  input wire logic xmit_bus,
  input wire logic xmit_rtrt,
  input wire logic [15:0] xmit_cmd,
  output logic resp_done,
  output logic [15:0] resp_status,
  output logic resp_error,
  output logic resp_none
);
  logic [15:0] ram [2048];
  logic [15:0] last_rd;
  logic [15:0] noise;
  logic [15:0] stat;
  logic err;
  logic mute;
  logic r_err;
  logic r_none;
  logic last_bus;
  logic last_rtrt;
  logic [15:0] last_cmd;
  int fails;
  int mem_lat;
  int resp_lat;
  int wait_cnt;
  int resp_cnt;
  int sends;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_cnt <= 0;
      last_rd <= 16'h0000;
    end else begin
      mem_ack <= mem_req && !mem_ack && wait_cnt >= mem_lat;
      wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 1 : 0;
      if (mem_req && mem_ack && mem_we) ram[mem_addr[10:0]] <= mem_wdata;
      if (mem_req && mem_ack) last_rd <= ram[mem_addr[10:0]];
    end
  end
  // read data is only meaningful at the answering edge
  assign mem_rdata = mem_ack ? ram[mem_addr[10:0]] : ~last_rd;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_done <= 1'b0;
      resp_cnt <= 0;
      noise <= 16'h0000;
    end else begin
      noise <= noise + 16'h3b5d;
      resp_done <= resp_cnt == 1;
      if (xmit_start) begin
        resp_cnt <= resp_lat;
        sends <= sends + 1;
        last_bus <= xmit_bus;
        last_rtrt <= xmit_rtrt;
        last_cmd <= xmit_cmd;
      end else if (resp_cnt > 0) begin
        resp_cnt <= resp_cnt - 1;
      end
      if (resp_cnt == 1) begin
        r_none <= fails > 0 || mute;
        r_err <= err && fails == 0;
        if (fails > 0) fails <= fails - 1;
      end
    end
  end
  assign resp_status = resp_done ? stat : noise;
  assign resp_error = resp_done ? r_err : noise[0];
  assign resp_none = resp_done ? r_none : noise[1];
endmodule : bcm_far_end

// *** test_bcm_msg_ctrl.sv ***
// test_bcm_msg_ctrl: self-checking bench for the message controller
// assumes bcm_far_end stands in for the ram and the remote terminals
module test_bcm_msg_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import bcm_pkg::*;
  logic clk, rst_n, cyc, stb, we, ack, mem_req, mem_we, mem_ack, xs, xb, xr, rd, re, rn, busy;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, seed;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, xcmd, rstat;
  int failures, compares;

  bcm_msg_ctrl uut (.SYS_CLK(clk), .RST_N(rst_n), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
    .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_W(dat_w), .WB_DAT_R(dat_r), .WB_ACK(ack),
    .MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .XMIT_START(xs), .XMIT_BUS(xb),
    .XMIT_RTRT(xr), .XMIT_CMD(xcmd), .RESP_DONE(rd), .RESP_STATUS(rstat),
    .RESP_ERROR(re), .RESP_NONE(rn), .BUSY(busy));
  bcm_far_end p (.clk(clk), .rst_n(rst_n), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .xmit_start(xs), .xmit_bus(xb), .xmit_rtrt(xr), .xmit_cmd(xcmd), .resp_done(rd),
    .resp_status(rstat),
    .resp_error(re), .resp_none(rn));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic mis(input logic [15:0] c, m, s, input logic mm);
    logic x;
    x = s[15:11] != m[15:11];
    x |= c[6] & (s[9] | s[0] | (|s[7:5]));
    x |= c[5] & s[8];
    x |= mm ? c[4] & s[4] : c[4] != s[4];
    x |= (c[3] & s[3]) | (c[2] & s[2]) | (c[1] & s[10]);
    return x;
  endfunction : mis

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    // hold the request until ack is seen high at a rising edge
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic settle();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b0 || n < 4);
  endtask : settle

  task automatic frame(input logic b, input logic [9:0] len);
    logic [31:0] r;
    p.sends = 0;
    wb(1'b1, b ? REG_FRAME_B_PTR : REG_FRAME_A_PTR, 32'h0000_0100, r);
    wb(1'b1, b ? REG_FRAME_B_LEN : REG_FRAME_A_LEN, {22'h0, len}, r);
    settle();
  endtask : frame

  task automatic one_msg(input logic [15:0] c, m, s, input logic [3:0] c1, input logic mm,
                         input int f);
    logic [31:0] r, y;
    logic [15:0] e;
    logic [1:0] sl;
    logic b0, lb, nf;
    int mx, rt;
    b0 = c1[0] ? c1[1] : c[7];
    sl = c[9:8] == RETRY_NONE ? c1[3:2] : c[9:8];
    mx = sl == RETRY_NONE ? 0 : (sl == RETRY_ALT_ACT ? 2 : 1);
    rt = (p.err || p.mute || f > mx) ? mx : f;
    lb = (rt == 1 && sl[1]) ? !b0 : b0;
    nf = p.mute || f > rt;
    e = {1'b1, rt > 0, !nf && mis(c, m, s, mm), p.err && f <= rt, nf, 1'b0, c[9:7] & 3'h6,
         c[6:0]} | {8'h00, lb, 7'h00};
    p.ram[64] = c;
    p.ram[65] = m;
    p.stat = s;
    p.fails = f;
    wb(1'b1, REG_CONFIG1, {28'h0, c1}, r);
    wb(1'b1, REG_CONFIG3, {26'h0, mm, 5'h0}, r);
    y = rnd();
    frame(y[0], 10'h001);
    check(p.ram[64], e);
    check(p.sends, rt + 1);
    check(p.last_bus, lb);
    check(p.last_rtrt, c[0]);
    check(p.last_cmd, m);
    wb(1'b0, REG_LAST_CTL, 32'h0, r);
    check(r[15:0], e);
  endtask : one_msg

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    stop_test();
  end

  initial begin
    logic [31:0] r, x, m, s;
    {rst_n, cyc, stb, we, adr, dat_w, failures, compares} = '0;
    sel = 4'hf;
    seed = 32'h22bedda7;
    {p.err, p.mute, p.stat, p.fails, p.mem_lat} = '0;
    p.resp_lat = 1;
    for (int i = 0; i < 1023; i++) p.ram[256 + i] = 16'h0040;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b1, REG_FRAME_A_PTR, 32'h0000_1234, r);
    wb(1'b0, REG_FRAME_A_PTR, 32'h0, r);
    check(r[15:0], 16'h1234);
    wb(1'b0, 8'h3c, 32'h0, r);
    check(r, 32'h0);
    // every local and global retry code, failing the first tries
    for (int i = 0; i < 16; i++) begin
      one_msg({6'h00, i[1:0], i[0], 7'h00}, 16'h0800, 16'h0800, {i[3:2], 2'b00}, 1'b0, 1 + i % 3);
    end
    // random setups, answers and pacing
    for (int i = 0; i < 40; i++) begin
      x = rnd();
      m = rnd();
      s = rnd();
      if (x[27]) s[15:11] = m[15:11];
      p.err = x[16] & x[17];
      p.mute = x[18] & x[19];
      p.mem_lat = x[21:20];
      p.resp_lat = 1 + x[26:22];
      one_msg({x[15:10], 2'b00, x[7:0]}, m[15:0], s[15:0], {2'b00, x[29:28]}, x[30], 0);
    end
    // longest list in one frame
    {p.err, p.mute, p.fails, p.mem_lat} = '0;
    p.resp_lat = 1;
    // stop during the first message, then restart by command
    p.sends = 0;
    wb(1'b1, REG_FRAME_A_PTR, 32'h0000_0100, r);
    wb(1'b1, REG_FRAME_A_LEN, 32'h0000_0005, r);
    wb(1'b1, REG_COMMAND, 32'h0000_0004, r);
    settle();
    wb(1'b0, REG_STATUS, 32'h0, r);
    check(r[25:16], 10'h001);
    wb(1'b1, REG_COMMAND, 32'h0000_0001, r);
    settle();
    check(p.sends, 6);
    frame(1'b1, 10'h3ff);
    wb(1'b0, REG_STATUS, 32'h0, r);
    check(r[25:16], 10'h3ff);
    check(r[1:0], 2'h2);
    check(p.sends, 1023);
    stop_test();
  end
endmodule : test_bcm_msg_ctrl
